// ==== hdh_buf2.v ====
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
`include "hdh_defs.vh"
module hdh_buf2
(
	input  wire                    clock,
	input  wire                    resetn,
	input  wire [`HDH_DATA_W-1:0]  in_data,
	input  wire                    in_valid,
	output wire                    in_ready,
	output wire [`HDH_DATA_W-1:0]  out_data,
	output wire                    out_valid,
	input  wire                    out_ready
);
	reg [`HDH_DATA_W-1:0] mem_q [0:1];
	reg                   wp_q;
	reg                   rp_q;
	reg [1:0]             cnt_q;
	reg                   inr_q;
	wire [1:0]            cnt_d;
	wire                  push;
	wire                  pop;

	// Handshakes on each side; full refuses input, empty hides output.
	assign in_ready  = inr_q;
	assign out_valid = (cnt_q != 2'h0);
	assign out_data  = mem_q[rp_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign cnt_d     = cnt_q + {1'b0, push} - {1'b0, pop};

	// Pointer and fill count update.
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			wp_q  <= 1'b0;
			rp_q  <= 1'b0;
			cnt_q <= 2'h0;
			inr_q <= 1'b1;
		end
		else
		begin
			if (push)
				wp_q <= ~wp_q;
			if (pop)
				rp_q <= ~rp_q;
			cnt_q <= cnt_d;
			// Ready is kept in a flop so the input side never sees a combinational path.
			inr_q <= (cnt_d != 2'h2);
		end
	end

	// Storage is written without reset.
	always @(posedge clock)
	begin
		if (push)
			mem_q[wp_q] <= in_data;
	end
endmodule
`default_nettype wire

// ==== hdh_defs.vh ====
// Constants shared by the disk DMA handshake block.
`ifndef HDH_DEFS_VH
`define HDH_DEFS_VH
`define HDH_CLK_PERIOD_NS 20
`define HDH_ACK_MAX_NS    250
// Longest time rounds down to whole cycles.
`define HDH_ACK_MAX_CYC   (`HDH_ACK_MAX_NS / `HDH_CLK_PERIOD_NS)
`define HDH_RATE_BPS      1000000
`define HDH_BYTE_NS       (1000000000 / `HDH_RATE_BPS)
`define HDH_DATA_W        8
`define HDH_CNT_W         4
`define HDH_ACK_HOLD_CYC  4'h2
`define HDH_ST_IDLE       2'h0
`define HDH_ST_ACK        2'h1
`define HDH_ST_WAIT_LOW   2'h2
`endif

// ==== hdh_disk_model.sv ====
// Behavioural off-board disk controller on the request port.
`timescale 1ns/1ps
`default_nettype none
module hdh_disk_model
(
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic       ack_n,
	input  wire logic       go,
	input  wire logic [7:0] byte_i,
	output var  logic       disk_port_request,
	output var  logic [7:0] port_data_i
);
	// Raise the request with data valid, drop it once answered, then scramble the lines.
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			disk_port_request <= 1'b0;
			port_data_i <= 8'h00;
		end
		else if (go)
		begin
			port_data_i <= byte_i;
			disk_port_request <= 1'b1;
		end
		else if (!ack_n)
			disk_port_request <= 1'b0;
		else if (!disk_port_request)
			port_data_i <= ~port_data_i;
	end
endmodule
`default_nettype wire

// ==== hdh_dma_handshake.v ====
// Device-side request/acknowledge handshake to an off-board disk controller.
`timescale 1ns/1ps
`default_nettype none
`include "hdh_defs.vh"
module hdh_dma_handshake
(
	input  wire                    clock,
	input  wire                    resetn,
	// Host side: command byte writes and transfer direction.
	input  wire                    cmd_valid,
	input  wire [`HDH_DATA_W-1:0]  cmd_data,
	output reg                     cmd_ready,
	input  wire                    dir_in,
	// Memory controller side, outbound words toward the disk.
	input  wire [`HDH_DATA_W-1:0]  mem_out_data,
	input  wire                    mem_out_valid,
	output wire                    mem_out_ready,
	// Memory controller side, inbound words from the disk.
	output reg  [`HDH_DATA_W-1:0]  mem_in_data,
	output reg                     mem_in_valid,
	input  wire                    mem_in_ready,
	// Disk port pins.
	input  wire                    disk_port_request,
	output reg                     disk_port_select_n,
	output reg                     address_line_one,
	output reg                     ack_n,
	input  wire [`HDH_DATA_W-1:0]  port_data_i,
	output reg  [`HDH_DATA_W-1:0]  port_data_o,
	output reg                     port_data_oe
);
	reg                   req_s1_q;
	reg                   req_s2_q;
	reg                   req_s3_q;
	reg [1:0]             st_q;
	reg [1:0]             st_d;
	reg [`HDH_CNT_W-1:0]  cnt_q;
	reg                   cmd_q;
	reg [`HDH_DATA_W-1:0] rx_q;
	reg                   rx_v_q;
	wire                  req_rise;
	wire                  ib_in_ready;
	wire [`HDH_DATA_W-1:0] ib_data;
	wire                  ib_valid;
	wire                  ib_ready;
	wire                  ob_valid;
	wire [`HDH_DATA_W-1:0] ob_data;
	wire                  can_serve;
	wire                  start_xfer;
	reg [`HDH_DATA_W-1:0] dat_s1_q;
	reg [`HDH_DATA_W-1:0] dat_s2_q;

	// Sequencer states in binary.
	localparam [1:0] ST_IDLE     = `HDH_ST_IDLE;
	localparam [1:0] ST_ACK      = `HDH_ST_ACK;
	localparam [1:0] ST_WAIT_LOW = `HDH_ST_WAIT_LOW;

	// Idle decode, shared by the buffer pop, the command take and the start.
	function is_idle;
		input [1:0] st;
		begin
			is_idle = (st == ST_IDLE);
		end
	endfunction

	// The request pin passes three flip-flops, the data lines two.
	// The data settle with the request, so both copies agree at the rise.
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_s3_q <= 1'b0;
			dat_s1_q <= {`HDH_DATA_W{1'b0}};
			dat_s2_q <= {`HDH_DATA_W{1'b0}};
		end
		else
		begin
			req_s1_q <= disk_port_request;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
			dat_s1_q <= port_data_i;
			dat_s2_q <= dat_s1_q;
		end
	end

	// A rising request from the controller starts every transfer.
	assign req_rise = req_s2_q & ~req_s3_q;

	// Outbound words from memory pass a two-entry buffer.
	hdh_buf2 u_obuf
	(
		.clock     (clock),
		.resetn    (resetn),
		.in_data   (mem_out_data),
		.in_valid  (mem_out_valid),
		.in_ready  (mem_out_ready),
		.out_data  (ob_data),
		.out_valid (ob_valid),
		.out_ready (is_idle(st_q) && req_rise && !cmd_q && !dir_in)
	);

	// Inbound bytes are buffered so a stalled memory side loses none.
	hdh_buf2 u_ibuf
	(
		.clock     (clock),
		.resetn    (resetn),
		.in_data   (rx_q),
		.in_valid  (rx_v_q),
		.in_ready  (ib_in_ready),
		.out_data  (ib_data),
		.out_valid (ib_valid),
		.out_ready (ib_ready)
	);
	assign ib_ready = ~mem_in_valid | mem_in_ready;

	// A request is served only when a byte or a free slot is at hand.
	assign can_serve = cmd_q ? 1'b1 : (dir_in ? ib_in_ready & ~rx_v_q : ob_valid);

	// A served request turns into an acknowledge on the next edge.
	assign start_xfer = is_idle(st_q) && (st_d == ST_ACK);

	// Handshake state: idle, acknowledge held, wait for request low.
	always @*
	begin
		st_d = st_q;
		case (st_q)
			ST_IDLE:
				if (req_rise && can_serve)
					st_d = ST_ACK;
			ST_ACK:
				if (cnt_q == `HDH_ACK_HOLD_CYC)
					st_d = ST_WAIT_LOW;
			ST_WAIT_LOW:
				if (!req_s2_q)
					st_d = ST_IDLE;
			default:
				st_d = ST_IDLE;
		endcase
	end

	// Sequencer, pins and data capture, all from flip-flops.
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q               <= ST_IDLE;
			cnt_q              <= {`HDH_CNT_W{1'b0}};
			cmd_q              <= 1'b0;
			cmd_ready          <= 1'b0;
			disk_port_select_n <= 1'b1;
			address_line_one   <= 1'b0;
			ack_n              <= 1'b1;
			port_data_o        <= {`HDH_DATA_W{1'b0}};
			port_data_oe       <= 1'b0;
			rx_q               <= {`HDH_DATA_W{1'b0}};
			rx_v_q             <= 1'b0;
			mem_in_data        <= {`HDH_DATA_W{1'b0}};
			mem_in_valid       <= 1'b0;
		end
		else
		begin
			st_q      <= st_d;
			cmd_ready <= 1'b0;
			rx_v_q    <= 1'b0;
			if (st_q == ST_ACK)
				cnt_q <= cnt_q + 4'h1;
			else
				cnt_q <= {`HDH_CNT_W{1'b0}};
			// Accept a command byte when idle; it goes out under select.
			if (is_idle(st_q) && !cmd_q && cmd_valid && !req_rise)
			begin
				cmd_q              <= 1'b1;
				cmd_ready          <= 1'b1;
				port_data_o        <= cmd_data;
				port_data_oe       <= 1'b1;
				disk_port_select_n <= 1'b0;
				address_line_one   <= 1'b1;
			end
			if (start_xfer)
			begin
				// Acknowledge one cycle after the synchronised rise, under 250 ns.
				ack_n <= 1'b0;
				if (!cmd_q && !dir_in)
				begin
					port_data_o  <= ob_data;
					port_data_oe <= 1'b1;
				end
				if (!cmd_q && dir_in)
				begin
					rx_q   <= dat_s2_q;
					rx_v_q <= 1'b1;
				end
			end
			// Release after one byte, well inside the 1000 ns byte slot.
			if (st_q == ST_ACK && st_d == ST_WAIT_LOW)
			begin
				ack_n              <= 1'b1;
				port_data_oe       <= 1'b0;
				cmd_q              <= 1'b0;
				disk_port_select_n <= 1'b1;
				address_line_one   <= 1'b0;
			end
			// Inbound bytes are presented to the memory controller.
			if (ib_valid && ib_ready)
			begin
				mem_in_data  <= ib_data;
				mem_in_valid <= 1'b1;
			end
			else if (mem_in_ready)
				mem_in_valid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== hdh_props.sv ====
// Port checker for the disk DMA handshake.
`timescale 1ns/1ps
`default_nettype none
`include "hdh_defs.vh"
module hdh_props
(
	input wire logic                   clock,
	input wire logic                   resetn,
	input wire logic                   cmd_ready,
	input wire logic [`HDH_DATA_W-1:0] mem_in_data,
	input wire logic                   mem_in_valid,
	input wire logic                   mem_in_ready,
	input wire logic                   disk_port_request,
	input wire logic                   disk_port_select_n,
	input wire logic                   address_line_one,
	input wire logic                   ack_n,
	input wire logic                   port_data_oe
);
	localparam int ACK_MAX = `HDH_ACK_MAX_CYC;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// The acknowledge stays low three cycles, then is released.
	sequence ack_pulse;
		!ack_n [*3] ##1 ack_n;
	endsequence
	ack_fast_a: assert property ($rose(disk_port_request) |-> ##[1:ACK_MAX] !ack_n)
		else $error("acknowledge late");
	ack_pulse_a: assert property ($fell(ack_n) |-> ack_pulse)
		else $error("acknowledge length wrong");
	sel_pair_a: assert property (disk_port_select_n != address_line_one)
		else $error("select and address line disagree");
	cmd_select_a: assert property (cmd_ready |-> !disk_port_select_n)
		else $error("command taken without select");
	cmd_drive_a: assert property ($fell(ack_n) && !disk_port_select_n |-> port_data_oe)
		else $error("command byte not driven");
	ack_req_a: assert property ($fell(ack_n) |-> disk_port_request)
		else $error("acknowledge without request");
	in_hold_a: assert property (mem_in_valid && !mem_in_ready |=> mem_in_valid && $stable(mem_in_data))
		else $error("inbound word lost");
endmodule
bind hdh_dma_handshake hdh_props u_hdh_props(.clock(clock), .resetn(resetn),
	.cmd_ready(cmd_ready), .mem_in_data(mem_in_data), .mem_in_valid(mem_in_valid),
	.mem_in_ready(mem_in_ready), .disk_port_request(disk_port_request),
	.disk_port_select_n(disk_port_select_n), .address_line_one(address_line_one),
	.ack_n(ack_n), .port_data_oe(port_data_oe));
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the disk DMA handshake.
`timescale 1ns/1ps
`default_nettype none
`include "hdh_defs.vh"
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin errors++; \
	$display("ERROR %s exp %h got %h", n, e, a); end end
`define WAIT(c) begin for (int k = 0; k < 20 && !(c); k++) @(negedge clock); \
	if (!(c)) begin errors++; report_and_stop; end end
module tb;
	logic       clock = 0, resetn = 0, cmd_valid = 0, dir_in = 0, go = 0;
	logic       mem_out_valid = 0, mem_in_ready = 0, mem_out_ready, mem_in_valid, cmd_ready;
	logic       disk_port_request, disk_port_select_n, address_line_one, ack_n, port_data_oe;
	logic [7:0] cmd_data = 0, mem_out_data = 0, byte_o = 0, mem_in_data, port_data_i, port_data_o;
	int         errors = 0, check_count = 0, cyc = 0;
	// Clock of 20 ns.
	always #10 clock = ~clock;
	// Free-running cycle count for throughput checks.
	always @(posedge clock) cyc <= cyc + 1;
	hdh_dma_handshake u_hdh_dma_handshake(.clock(clock), .resetn(resetn), .cmd_valid(cmd_valid),
		.cmd_data(cmd_data), .cmd_ready(cmd_ready), .dir_in(dir_in), .mem_out_data(mem_out_data),
		.mem_out_valid(mem_out_valid), .mem_out_ready(mem_out_ready), .mem_in_data(mem_in_data),
		.mem_in_valid(mem_in_valid), .mem_in_ready(mem_in_ready), .disk_port_request(disk_port_request),
		.disk_port_select_n(disk_port_select_n), .address_line_one(address_line_one), .ack_n(ack_n),
		.port_data_i(port_data_i), .port_data_o(port_data_o), .port_data_oe(port_data_oe));
	hdh_disk_model u_hdh_disk_model(.clock(clock), .resetn(resetn), .ack_n(ack_n), .go(go), .byte_i(byte_o),
		.disk_port_request(disk_port_request), .port_data_i(port_data_i));
	task report_and_stop;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// One disk request, returning once the acknowledge is low.
	task transfer(input logic [7:0] b);
		byte_o = b;
		go = 1;
		@(negedge clock);
		go = 0;
		`WAIT(!ack_n)
	endtask
	task test_cmd;
		cmd_data = 8'h12;
		cmd_valid = 1;
		`WAIT(cmd_ready)
		cmd_valid = 0;
		`CHK("select", 1'b0, disk_port_select_n)
		`CHK("addr", 1'b1, address_line_one)
		transfer(8'h00);
		`CHK("cmd byte", 8'h12, port_data_o)
		`WAIT(ack_n)
		`CHK("deselect", 1'b1, disk_port_select_n)
		`CHK("addr low", 1'b0, address_line_one)
		$display("test_cmd done");
	endtask
	task test_out;
		int t0;
		mem_out_data = 8'h5a;
		mem_out_valid = 1;
		@(negedge clock);
		mem_out_data = 8'ha5;
		@(negedge clock);
		mem_out_valid = 0;
		`CHK("full", 1'b0, mem_out_ready)
		t0 = cyc;
		transfer(8'h00);
		`CHK("out 1", 8'h5a, port_data_o)
		`CHK("oe on", 1'b1, port_data_oe)
		`WAIT(ack_n)
		`CHK("oe off", 1'b0, port_data_oe)
		transfer(8'h00);
		`CHK("out 2", 8'ha5, port_data_o)
		`WAIT(ack_n)
		`CHK("rate", 1'b1, (cyc - t0) <= 2 * `HDH_BYTE_NS / `HDH_CLK_PERIOD_NS)
		$display("test_out done");
	endtask
	// Reset in mid-run with a command pending and the outbound buffer full.
	task test_reset;
		cmd_data = 8'h34;
		cmd_valid = 1;
		mem_out_valid = 1;
		@(negedge clock);
		cmd_valid = 0;
		@(negedge clock);
		mem_out_valid = 0;
		`CHK("pre sel", 1'b0, disk_port_select_n)
		`CHK("pre full", 1'b0, mem_out_ready)
		resetn = 0;
		#1;
		`CHK("rst ack", 1'b1, ack_n)
		`CHK("rst sel", 1'b1, disk_port_select_n)
		`CHK("rst ready", 1'b1, mem_out_ready)
		@(negedge clock);
		resetn = 1;
		@(negedge clock);
		`CHK("rst addr", 1'b0, address_line_one)
		$display("test_reset done");
	endtask
	task test_in;
		dir_in = 1;
		transfer(8'hc3);
		`WAIT(ack_n)
		transfer(8'h3c);
		`WAIT(ack_n)
		`CHK("in 1", 8'hc3, mem_in_data)
		mem_in_ready = 1;
		@(negedge clock);
		`CHK("in 2", 8'h3c, mem_in_data)
		@(negedge clock);
		`CHK("empty", 1'b0, mem_in_valid)
		$display("test_in done");
	endtask
	// Reset for three cycles, then the scenarios.
	initial
	begin
		repeat (3) @(negedge clock);
		resetn = 1;
		@(negedge clock);
		test_cmd;
		test_out;
		test_in;
		test_reset;
		report_and_stop;
	end
endmodule
`default_nettype wire
